// ==== hw/apseq_defines.vh ====
`ifndef APSEQ_DEFINES_VH
`define APSEQ_DEFINES_VH
// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define APSEQ_A_FEAT_PICK   8'h00
`define APSEQ_A_FEAT_ON     8'h04
`define APSEQ_A_CTRL        8'h08
`define APSEQ_A_SET_PICK    8'h0c
`define APSEQ_A_CMD         8'h10
`define APSEQ_A_STATUS      8'h14
`define APSEQ_A_LIVE_BASE   8'h20
`define APSEQ_A_CLASS_BASE  8'h40
`define APSEQ_A_PATH        8'h60
`define APSEQ_A_START       8'h64
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define APSEQ_B_CFG_MODE    0
`define APSEQ_B_RUN_MODE    1
`define APSEQ_B_STORE       0
`define APSEQ_B_RECALL      1
`define APSEQ_B_CFG_LEGAL   0
`define APSEQ_B_SET_LEGAL   1
`define APSEQ_NFEAT         8
`define APSEQ_NSET          8
`define APSEQ_IDXW          3
`define APSEQ_FEATW         16
// feature classes
`define APSEQ_CL_NONE       3'h0
`define APSEQ_CL_DIRECT     3'h1
`define APSEQ_CL_IMPLIED    3'h2
`define APSEQ_CL_FIXED      3'h3
`define APSEQ_CL_FORCED     3'h4
// axi response
`define APSEQ_RESP_OKAY     2'h0
`define APSEQ_RESP_SLVERR   2'h2
`endif

// ==== hw/apseq_set_mem.v ====
`include "apseq_defines.vh"
// per-set storage of all feature values; registered read port
module apseq_set_mem (
  input  wire                                 clk_in,
  input  wire                                 ce_in,
  input  wire                                 we_in,
  input  wire [`APSEQ_IDXW-1:0]               addr_in,
  input  wire [`APSEQ_NFEAT*`APSEQ_FEATW-1:0] wdata_in,
  output reg  [`APSEQ_NFEAT*`APSEQ_FEATW-1:0] rdata_out
);
  reg [`APSEQ_NFEAT*`APSEQ_FEATW-1:0] mem_r [0:`APSEQ_NSET-1];
  always @(posedge clk_in) begin
    if (ce_in) begin
      if (we_in) begin
        mem_r[addr_in] <= wdata_in;
      end
      rdata_out <= mem_r[addr_in];
    end
  end
endmodule // apseq_set_mem

// ==== hw/apseq_class.v ====
`include "apseq_defines.vh"
// resolves class of each feature from the direct set and dependency web
// dep_in[i*N+j] high: feature i's range depends on feature j
module apseq_class (
  input  wire [`APSEQ_NFEAT-1:0]              direct_in,
  input  wire [`APSEQ_NFEAT-1:0]              auto_in,
  input  wire [`APSEQ_NFEAT*`APSEQ_NFEAT-1:0] dep_in,
  output wire [`APSEQ_NFEAT-1:0]              implied_out,
  output wire [`APSEQ_NFEAT-1:0]              fixed_out,
  output wire [`APSEQ_NFEAT-1:0]              forced_out
);
  wire [`APSEQ_NFEAT-1:0] fix_lvl [0:`APSEQ_NFEAT];
  genvar i, k;
  generate
    for (i = 0; i < `APSEQ_NFEAT; i = i + 1) begin : g_imp
      wire [`APSEQ_NFEAT-1:0] row = dep_in[i*`APSEQ_NFEAT +: `APSEQ_NFEAT];
      // ranges touched by a direct feature become implied
      assign implied_out[i] = ~direct_in[i] & ~auto_in[i] &
                              (|(row & direct_in)); // [R17]
      assign forced_out[i]  = auto_in[i] & ~direct_in[i];
    end
    // seed: preconditions of direct or implied features
    for (i = 0; i < `APSEQ_NFEAT; i = i + 1) begin : g_seed
      wire [`APSEQ_NFEAT-1:0] hit;
      for (k = 0; k < `APSEQ_NFEAT; k = k + 1) begin : g_s
        assign hit[k] = dep_in[k*`APSEQ_NFEAT+i] &
                        (direct_in[k] | implied_out[k]);
      end
      assign fix_lvl[0][i] = |hit; // [R16]
    end
    // chain closure over N levels
    for (k = 0; k < `APSEQ_NFEAT; k = k + 1) begin : g_lvl
      for (i = 0; i < `APSEQ_NFEAT; i = i + 1) begin : g_f
        wire [`APSEQ_NFEAT-1:0] col;
        genvar m;
        for (m = 0; m < `APSEQ_NFEAT; m = m + 1) begin : g_c
          assign col[m] = dep_in[m*`APSEQ_NFEAT+i] & fix_lvl[k][m];
        end
        assign fix_lvl[k+1][i] = fix_lvl[k][i] | (|col); // [R18]
      end
    end
  endgenerate
  assign fixed_out = fix_lvl[`APSEQ_NFEAT] & ~direct_in & ~implied_out;
endmodule // apseq_class

// ==== hw/apseq_top.v ====
// ----------------------------------------------------------------------
// Overview of operation
// R1 - each set stores own direct values
// R2 - implied stored per set, locked while running
// R3 - fixed features write protected in config and run
// R4 - auto features forced off while running
// R5 - non sequenced features untouched
// R6 - host enables direct features before config
// R7 - direct enable applies to all sets
// R8 - config entry resolves classes, locks fixed
// R9 - host exits config to change fixed
// R10 - store copies live values into picked set
// R11 - store checks set, updates legal flag
// R12 - store may invalidate other saved sets
// R13 - eight sets addressed by set index
// R14 - recall loads legal set when not running
// R15 - saved set holds all live values
// R16 - bounding feature of direct becomes fixed
// R17 - feature bounded by direct becomes implied
// R18 - fixed class propagates along dependencies
// R19 - run on locks sequenced features, loads start set
// R20 - path trigger advances set, index reported
// R21 - run off leaves last set live
// R22 - config exit checks, publishes legal flag
// R23 - set indexes three bits wide
// ----------------------------------------------------------------------
`include "apseq_defines.vh"
module apseq_top (
  input  wire                                 CLK_SYS_IN,
  input  wire                                 RST_B_IN,
  input  wire                                 CE_IN,
  input  wire [7:0]                           S_AXI_AWADDR_IN,
  input  wire                                 S_AXI_AWVALID_IN,
  output reg                                  S_AXI_AWREADY_OUT,
  input  wire [31:0]                          S_AXI_WDATA_IN,
  input  wire [3:0]                           S_AXI_WSTRB_IN,
  input  wire                                 S_AXI_WVALID_IN,
  output reg                                  S_AXI_WREADY_OUT,
  output reg  [1:0]                           S_AXI_BRESP_OUT,
  output reg                                  S_AXI_BVALID_OUT,
  input  wire                                 S_AXI_BREADY_IN,
  input  wire [7:0]                           S_AXI_ARADDR_IN,
  input  wire                                 S_AXI_ARVALID_IN,
  output reg                                  S_AXI_ARREADY_OUT,
  output reg  [31:0]                          S_AXI_RDATA_OUT,
  output reg  [1:0]                           S_AXI_RRESP_OUT,
  output reg                                  S_AXI_RVALID_OUT,
  input  wire                                 S_AXI_RREADY_IN,
  input  wire [`APSEQ_NFEAT-1:0]              FEAT_AUTO_IN,
  input  wire [`APSEQ_NFEAT*`APSEQ_NFEAT-1:0] FEAT_DEP_IN,
  input  wire                                 TRIG_IN,
  output reg  [`APSEQ_NFEAT*`APSEQ_FEATW-1:0] LIVE_OUT,
  output reg  [`APSEQ_IDXW-1:0]               CURRENT_SET_INDEX_OUT,
  output reg                                  RUN_MODE_OUT
);
  localparam N = `APSEQ_NFEAT;
  localparam W = `APSEQ_FEATW;
  localparam S_IDLE = 2'h0;
  localparam S_RD   = 2'h1;
  localparam S_STO  = 2'h2;
  localparam S_LD   = 2'h3;
  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  reg trig_s1_r, trig_s2_r, trig_s3_r;
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_s3_r <= 1'b0;
    end else if (CE_IN) begin
      trig_s1_r <= TRIG_IN;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
    end
  end
  wire trig_rise = trig_s2_r & ~trig_s3_r;
  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  reg  [`APSEQ_IDXW-1:0] direct_feature_pick_r;
  reg  [N-1:0]           direct_feature_on_r;
  reg                    config_mode_switch_r;
  reg                    run_mode_switch_r;
  reg  [`APSEQ_IDXW-1:0] set_index_pick_r;
  reg  [`APSEQ_NSET-1:0] set_legal_flag_r;
  reg  [`APSEQ_NSET-1:0] set_saved_r;
  reg                    config_legal_flag_r;
  reg  [N-1:0]           implied_r, fixed_r, forced_r;
  reg  [`APSEQ_IDXW-1:0] next_set_r [0:`APSEQ_NSET-1];
  reg  [`APSEQ_IDXW-1:0] start_set_r;
  reg  [N*W-1:0]         live_r;
  reg  [1:0]             st_r;
  reg  [`APSEQ_IDXW-1:0] mem_addr_r;
  reg  [N*W-1:0]         saved_snap_r;
  wire [N*W-1:0]         mem_rdata;
  wire [N-1:0]           imp_w, fix_w, frc_w;
  wire [N-1:0]           wr_lock;
  wire [N-1:0]           seq_w;
  apseq_class u_class (
    .direct_in   (direct_feature_on_r),
    .auto_in     (FEAT_AUTO_IN),
    .dep_in      (FEAT_DEP_IN),
    .implied_out (imp_w),
    .fixed_out   (fix_w),
    .forced_out  (frc_w)
  );
  wire mem_we = CE_IN & (st_r == S_STO);
  apseq_set_mem u_mem (
    .clk_in    (CLK_SYS_IN),
    .ce_in     (CE_IN),
    .we_in     (mem_we),
    .addr_in   (mem_addr_r),
    .wdata_in  (live_r), // [R15] [R10]
    .rdata_out (mem_rdata)
  );
  // lock vector: fixed always in config, everything sequenced when running
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_lock
      assign seq_w[g] = direct_feature_on_r[g] | implied_r[g] | fixed_r[g] |
                        forced_r[g];
      assign wr_lock[g] = (config_mode_switch_r & fixed_r[g]) | // [R3]
                          (run_mode_switch_r & seq_w[g]); // [R2] [R19]
    end
  endgenerate
  // ----------------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------------
  reg        aw_got_r, w_got_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  wire do_wr = aw_got_r & w_got_r & ~S_AXI_BVALID_OUT;
  wire do_rd = S_AXI_ARVALID_IN & S_AXI_ARREADY_OUT;
  wire wr_live = awaddr_r[7:5] == 3'h1;
  wire [2:0] wr_feat = awaddr_r[4:2];
  wire wr_map = wr_live | (awaddr_r <= `APSEQ_A_CMD) |
                (awaddr_r == `APSEQ_A_PATH) | (awaddr_r == `APSEQ_A_START);
  reg [31:0] rd_val;
  reg        rd_ok;
  always @* begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (S_AXI_ARADDR_IN[7:5] == 3'h1) begin
      rd_val[W-1:0] = live_r[S_AXI_ARADDR_IN[4:2]*W +: W];
    end else if (S_AXI_ARADDR_IN[7:5] == 3'h2) begin
      rd_val[2:0] = {forced_r[S_AXI_ARADDR_IN[4:2]] ? 3'h4 :
                     fixed_r[S_AXI_ARADDR_IN[4:2]] ? 3'h3 :
                     implied_r[S_AXI_ARADDR_IN[4:2]] ? 3'h2 :
                     direct_feature_on_r[S_AXI_ARADDR_IN[4:2]] ? 3'h1 :
                     3'h0};
    end else begin
      case (S_AXI_ARADDR_IN)
        `APSEQ_A_FEAT_PICK: rd_val[2:0] = direct_feature_pick_r;
        `APSEQ_A_FEAT_ON:   rd_val[N-1:0] = direct_feature_on_r;
        `APSEQ_A_CTRL:      rd_val[1:0] = {run_mode_switch_r,
                                           config_mode_switch_r};
        `APSEQ_A_SET_PICK:  rd_val[2:0] = set_index_pick_r;
        `APSEQ_A_CMD:       rd_val[1:0] = {st_r == S_LD, st_r == S_STO};
        `APSEQ_A_STATUS:    rd_val[4:0] = {CURRENT_SET_INDEX_OUT, // [R20]
                              set_legal_flag_r[set_index_pick_r], // [R11]
                              config_legal_flag_r}; // [R22]
        `APSEQ_A_PATH:      rd_val[2:0] = next_set_r[set_index_pick_r];
        `APSEQ_A_START:     rd_val[2:0] = start_set_r;
        default:            rd_ok = 1'b0;
      endcase
    end
  end
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      S_AXI_AWREADY_OUT <= 1'b1;
      S_AXI_WREADY_OUT  <= 1'b1;
      S_AXI_BVALID_OUT  <= 1'b0;
      S_AXI_BRESP_OUT   <= `APSEQ_RESP_OKAY;
      S_AXI_ARREADY_OUT <= 1'b1;
      S_AXI_RVALID_OUT  <= 1'b0;
      S_AXI_RDATA_OUT   <= 32'h0;
      S_AXI_RRESP_OUT   <= `APSEQ_RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0;
    end else if (CE_IN) begin
      if (S_AXI_AWVALID_IN & S_AXI_AWREADY_OUT) begin
        aw_got_r <= 1'b1;
        awaddr_r <= S_AXI_AWADDR_IN;
        S_AXI_AWREADY_OUT <= 1'b0;
      end
      if (S_AXI_WVALID_IN & S_AXI_WREADY_OUT) begin
        w_got_r <= 1'b1;
        wdata_r <= S_AXI_WDATA_IN;
        S_AXI_WREADY_OUT <= 1'b0;
      end
      if (do_wr) begin
        S_AXI_BVALID_OUT <= 1'b1;
        S_AXI_BRESP_OUT <= wr_map ? `APSEQ_RESP_OKAY : `APSEQ_RESP_SLVERR;
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
      end
      if (S_AXI_BVALID_OUT & S_AXI_BREADY_IN) begin
        S_AXI_BVALID_OUT  <= 1'b0;
        S_AXI_AWREADY_OUT <= 1'b1;
        S_AXI_WREADY_OUT  <= 1'b1;
      end
      if (do_rd) begin
        S_AXI_ARREADY_OUT <= 1'b0;
        S_AXI_RVALID_OUT  <= 1'b1;
        S_AXI_RDATA_OUT   <= rd_val;
        S_AXI_RRESP_OUT   <= rd_ok ? `APSEQ_RESP_OKAY : `APSEQ_RESP_SLVERR;
      end
      if (S_AXI_RVALID_OUT & S_AXI_RREADY_IN) begin
        S_AXI_RVALID_OUT  <= 1'b0;
        S_AXI_ARREADY_OUT <= 1'b1;
      end
    end
  end
  // ----------------------------------------------------------------------
  // sequencer control
  // ----------------------------------------------------------------------
  wire wr_ctrl  = do_wr & (awaddr_r == `APSEQ_A_CTRL);
  wire cfg_on   = wr_ctrl & wdata_r[`APSEQ_B_CFG_MODE] & ~config_mode_switch_r;
  wire cfg_off  = wr_ctrl & ~wdata_r[`APSEQ_B_CFG_MODE] & config_mode_switch_r;
  wire run_on   = wr_ctrl & wdata_r[`APSEQ_B_RUN_MODE] & ~run_mode_switch_r &
                  config_legal_flag_r & ~config_mode_switch_r;
  wire run_off  = wr_ctrl & ~wdata_r[`APSEQ_B_RUN_MODE] & run_mode_switch_r;
  wire wr_cmd   = do_wr & (awaddr_r == `APSEQ_A_CMD) & (st_r == S_IDLE);
  wire store_go = wr_cmd & wdata_r[`APSEQ_B_STORE] & config_mode_switch_r;
  wire recall_go = wr_cmd & wdata_r[`APSEQ_B_RECALL] &
                   set_legal_flag_r[set_index_pick_r] &
                   ~run_mode_switch_r; // [R14]
  wire adv = run_mode_switch_r & trig_rise & (st_r == S_IDLE);
  // every saved set must be legal and the path must stay among them
  wire [`APSEQ_NSET-1:0] path_ok;
  generate
    for (g = 0; g < `APSEQ_NSET; g = g + 1) begin : g_path
      assign path_ok[g] = ~set_saved_r[g] |
                          (set_legal_flag_r[g] &
                           set_legal_flag_r[next_set_r[g]]);
    end
  endgenerate
  wire cfg_check = (&path_ok) & set_legal_flag_r[start_set_r];
  // a stored value is legal when no fixed feature moved since config entry
  wire store_legal = ~|((live_r ^ saved_snap_r) & fixed_mask(fixed_r));
  function [N*W-1:0] fixed_mask;
    input [N-1:0] f;
    integer j;
    begin
      for (j = 0; j < N; j = j + 1) begin
        fixed_mask[j*W +: W] = {W{f[j]}};
      end
    end
  endfunction
  integer n;
  always @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) begin
      direct_feature_pick_r <= 3'h0;
      direct_feature_on_r   <= {N{1'b0}};
      config_mode_switch_r  <= 1'b0;
      run_mode_switch_r     <= 1'b0;
      set_index_pick_r      <= 3'h0;
      set_legal_flag_r      <= {`APSEQ_NSET{1'b0}};
      set_saved_r           <= {`APSEQ_NSET{1'b0}};
      config_legal_flag_r   <= 1'b0;
      implied_r <= {N{1'b0}};
      fixed_r   <= {N{1'b0}};
      forced_r  <= {N{1'b0}};
      start_set_r <= 3'h0;
      live_r      <= {N*W{1'b0}};
      saved_snap_r <= {N*W{1'b0}};
      st_r        <= S_IDLE;
      mem_addr_r  <= 3'h0;
      CURRENT_SET_INDEX_OUT <= 3'h0;
      LIVE_OUT     <= {N*W{1'b0}};
      RUN_MODE_OUT <= 1'b0;
      for (n = 0; n < `APSEQ_NSET; n = n + 1) begin
        next_set_r[n] <= 3'h0;
      end
    end else if (CE_IN) begin
      if (do_wr & ~config_mode_switch_r & ~run_mode_switch_r) begin
        if (awaddr_r == `APSEQ_A_FEAT_PICK) begin
          direct_feature_pick_r <= wdata_r[2:0];
        end
        if (awaddr_r == `APSEQ_A_FEAT_ON) begin
          // one enable bit for the whole sequence, not per set
          direct_feature_on_r[direct_feature_pick_r] <= wdata_r[0]; // [R7]
        end
      end
      if (do_wr & (awaddr_r == `APSEQ_A_SET_PICK)) begin
        set_index_pick_r <= wdata_r[`APSEQ_IDXW-1:0]; // [R13] [R23]
      end
      if (do_wr & config_mode_switch_r) begin
        if (awaddr_r == `APSEQ_A_PATH) begin
          next_set_r[set_index_pick_r] <= wdata_r[2:0];
        end
        if (awaddr_r == `APSEQ_A_START) begin
          start_set_r <= wdata_r[2:0];
        end
      end
      if (cfg_on & ~run_mode_switch_r) begin
        config_mode_switch_r <= 1'b1;
        implied_r <= imp_w; // [R8]
        fixed_r   <= fix_w; // [R8]
        forced_r  <= frc_w;
        saved_snap_r <= live_r;
        config_legal_flag_r <= 1'b0;
      end
      if (cfg_off) begin
        config_mode_switch_r <= 1'b0;
        config_legal_flag_r  <= cfg_check; // [R22]
      end
      if (run_on) begin
        run_mode_switch_r <= 1'b1; // [R19]
        mem_addr_r <= start_set_r;
        CURRENT_SET_INDEX_OUT <= start_set_r;
        st_r <= S_RD;
      end
      if (run_off) begin
        run_mode_switch_r <= 1'b0; // live_r left as last set [R21]
      end
      if (store_go) begin
        mem_addr_r <= set_index_pick_r;
        st_r <= S_STO;
      end
      if (recall_go) begin
        mem_addr_r <= set_index_pick_r;
        st_r <= S_RD;
      end
      if (adv) begin
        mem_addr_r <= next_set_r[CURRENT_SET_INDEX_OUT];
        CURRENT_SET_INDEX_OUT <= next_set_r[CURRENT_SET_INDEX_OUT]; // [R20]
        st_r <= S_RD;
      end
      case (st_r)
        S_IDLE: ;
        S_RD:   st_r <= S_LD;
        S_STO: begin
          set_saved_r[mem_addr_r] <= 1'b1;
          // a fresh store rechecks and can knock out other sets
          for (n = 0; n < `APSEQ_NSET; n = n + 1) begin
            if (n != mem_addr_r) begin
              set_legal_flag_r[n] <= set_legal_flag_r[n] &
                                     store_legal; // [R12]
            end
          end
          set_legal_flag_r[mem_addr_r] <= store_legal; // [R11] [R1]
          st_r <= S_IDLE;
        end
        S_LD: begin
          // non-sequenced features keep their value
          live_r <= (mem_rdata & fixed_mask(seq_w)) |
                    (live_r & ~fixed_mask(seq_w)); // [R14] [R19] [R5]
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
      // host write beats a load
      if (do_wr & wr_live & ~wr_lock[wr_feat]) begin
        live_r[wr_feat*W +: W] <= wdata_r[W-1:0]; // [R5] [R4]
      end
      if (run_mode_switch_r) begin
        for (n = 0; n < N; n = n + 1) begin
          if (forced_r[n]) begin
            LIVE_OUT[n*W +: W] <= {W{1'b0}}; // auto forced off [R4]
          end else begin
            LIVE_OUT[n*W +: W] <= live_r[n*W +: W];
          end
        end
      end else begin
        LIVE_OUT <= live_r;
      end
      RUN_MODE_OUT <= run_mode_switch_r;
    end
  end
endmodule // apseq_top

// ==== tb/apseq_props.sv ====
// ------------------------------------------------------------
// port checks for the sequencer
// ------------------------------------------------------------
module apseq_props (
  input logic         CLK_SYS_IN,
  input logic         RST_B_IN,
  input logic         S_AXI_AWVALID_IN,
  input logic         S_AXI_AWREADY_OUT,
  input logic         S_AXI_WVALID_IN,
  input logic         S_AXI_WREADY_OUT,
  input logic         S_AXI_BVALID_OUT,
  input logic         S_AXI_BREADY_IN,
  input logic         S_AXI_ARVALID_IN,
  input logic         S_AXI_ARREADY_OUT,
  input logic         S_AXI_RVALID_OUT,
  input logic         S_AXI_RREADY_IN,
  input logic         TRIG_IN,
  input logic [7:0]   FEAT_AUTO_IN,
  input logic [127:0] LIVE_OUT,
  input logic [2:0]   CURRENT_SET_INDEX_OUT,
  input logic         RUN_MODE_OUT
);
  logic [3:0]   trig_age_r;
  logic [127:0] live_seq;
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_B_IN);
  // saturating, so an old pulse never excuses a set change
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RST_B_IN) trig_age_r <= 4'hf;
    else if (TRIG_IN) trig_age_r <= 4'h0;
    else if (trig_age_r != 4'hf) trig_age_r <= trig_age_r + 4'h1;
  end
  always_comb begin
    live_seq = LIVE_OUT;
    for (int i = 0; i < 8; i++)
      if (FEAT_AUTO_IN[i]) live_seq[16*i +: 16] = 16'h0;
  end
  AST_BVALID_HOLD:
  assert property (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN |=> S_AXI_BVALID_OUT)
    else $error("bvalid dropped before bready");
  AST_RVALID_HOLD:
  assert property (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN |=> S_AXI_RVALID_OUT)
    else $error("rvalid dropped before rready");
  AST_B_ANSWER:
  assert property (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT && S_AXI_WVALID_IN
    && S_AXI_WREADY_OUT |=> !S_AXI_AWREADY_OUT ##1 S_AXI_BVALID_OUT)
    else $error("write answer late");
  AST_R_ANSWER:
  assert property (S_AXI_ARVALID_IN && S_AXI_ARREADY_OUT |=> S_AXI_RVALID_OUT)
    else $error("read answer late");
  AST_W_REFUSE:
  assert property (S_AXI_BVALID_OUT |-> !S_AXI_AWREADY_OUT && !S_AXI_WREADY_OUT)
    else $error("write taken during response");
  AST_AR_REFUSE:
  assert property (S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
    else $error("read taken during response");
  AST_FORCED_OFF:
  assert property (RUN_MODE_OUT && $past(RUN_MODE_OUT, 6) |-> live_seq == LIVE_OUT)
    else $error("auto feature not forced off");
  AST_IDX_TRIG:
  assert property (RUN_MODE_OUT && $past(RUN_MODE_OUT, 6)
    && !$stable(CURRENT_SET_INDEX_OUT) |-> trig_age_r < 4'hc)
    else $error("set index moved without trigger");
  AST_RUN_OFF_KEEP:
  assert property ($fell(RUN_MODE_OUT) |-> $stable(live_seq) ##1 $stable(live_seq))
    else $error("live values moved at run off");
endmodule // apseq_props
bind apseq_top apseq_props u_props (.CLK_SYS_IN, .RST_B_IN, .S_AXI_AWVALID_IN,
  .S_AXI_AWREADY_OUT, .S_AXI_WVALID_IN, .S_AXI_WREADY_OUT, .S_AXI_BVALID_OUT,
  .S_AXI_BREADY_IN, .S_AXI_ARVALID_IN, .S_AXI_ARREADY_OUT, .S_AXI_RVALID_OUT,
  .S_AXI_RREADY_IN, .TRIG_IN, .FEAT_AUTO_IN, .LIVE_OUT, .CURRENT_SET_INDEX_OUT,
  .RUN_MODE_OUT);

// ==== tb/test_apseq_top.sv ====
// ------------------------------------------------------------
// sequencer bench with integer model
// ------------------------------------------------------------
`include "apseq_defines.vh"
module test_apseq_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk = 1'b0, rst_b = 1'b0, trig = 1'b0;
  logic [7:0]   awaddr = 8'h0, araddr = 8'h0;
  logic [31:0]  wdata = 32'h0, rd_v;
  logic         awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  wire          awready, wready, bvalid, arready, rvalid, run;
  wire  [1:0]   bresp, rresp;
  wire  [31:0]  rdata;
  wire  [127:0] live;
  wire  [2:0]   idx;
  logic [7:0]   auto_m = 8'h08, dir_m = 8'h22;
  logic [63:0]  dep_m = 64'h4000_0000_0082_0100;
  int           error_cnt = 0, cmp_count = 0, cyc = 0;
  int           live_m [8], set_m [8][8], cls [8];
  always #4 clk = ~clk;
  apseq_top uut (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .CE_IN(1'b1),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid),
    .S_AXI_AWREADY_OUT(awready), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hf), .S_AXI_WVALID_IN(wvalid), .S_AXI_WREADY_OUT(wready),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arvalid), .S_AXI_ARREADY_OUT(arready),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready),
    .FEAT_AUTO_IN(auto_m), .FEAT_DEP_IN(dep_m), .TRIG_IN(trig),
    .LIVE_OUT(live), .CURRENT_SET_INDEX_OUT(idx), .RUN_MODE_OUT(run));
  task automatic end_sim();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1);
    chk({30'h0, bresp}, {30'h0, a < 8'h68 ? 2'h0 : 2'h2});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, m);
    int n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    rd_v = rdata;
    chk({30'h0, rresp}, {30'h0, a < 8'h68 ? 2'h0 : 2'h2});
    chk(rd_v & m, e);
  endtask
  // forced features are skipped while running, the checker watches them
  task automatic chk_live(input logic [7:0] skip);
    @(posedge clk); // last write needs an edge to reach the port
    for (int i = 0; i < 8; i++)
      if (!skip[i]) chk({16'h0, live[16*i +: 16]}, live_m[i]);
  endtask
  function automatic logic [7:0] fa(input logic [7:0] b, input int i);
    return b + 8'(4 * i);
  endfunction
  function automatic void load_m(input int s);
    for (int i = 0; i < 8; i++)
      if (cls[i] != 0) live_m[i] = set_m[s][i];
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t timeout", $time);
      end_sim();
    end
  end
  initial begin
    void'($urandom(32'hdc7d5257));
    for (int i = 0; i < 8; i++)
      cls[i] = dir_m[i] ? 1 : (auto_m[i] ? 4 : 0);
    for (int i = 0; i < 8; i++)
      for (int j = 0; j < 8; j++)
        if (dep_m[i*8+j] && dir_m[j] && !dir_m[i]) cls[i] = 2;
    repeat (8)
      for (int i = 0; i < 8; i++)
        for (int j = 0; j < 8; j++)
          if (dep_m[i*8+j] && cls[i] inside {1, 2, 3} && cls[j] == 0)
            cls[j] = 3;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    wr(8'h80, 32'h0);
    rdc(8'h80, 32'h0, 32'h0);
    for (int i = 0; i < 8; i++) begin
      live_m[i] = $urandom & 16'hffff;
      wr(fa(`APSEQ_A_LIVE_BASE, i), live_m[i]);
    end
    chk_live(8'h00);
    for (int i = 0; i < 8; i++)
      if (dir_m[i]) begin
        wr(`APSEQ_A_FEAT_PICK, i);
        wr(`APSEQ_A_FEAT_ON, 32'h1);
      end
    wr(`APSEQ_A_CTRL, 32'h1);
    for (int i = 0; i < 8; i++)
      rdc(fa(`APSEQ_A_CLASS_BASE, i), cls[i], 32'h7);
    for (int i = 0; i < 8; i++) begin
      rd_v = $urandom & 16'hffff;
      wr(fa(`APSEQ_A_LIVE_BASE, i), rd_v);
      if (cls[i] != 3) live_m[i] = rd_v;
    end
    chk_live(8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(`APSEQ_A_SET_PICK, s);
      for (int i = 0; i < 8; i++)
        if (cls[i] inside {1, 2}) begin
          live_m[i] = $urandom & 16'hffff;
          wr(fa(`APSEQ_A_LIVE_BASE, i), live_m[i]);
        end
      wr(`APSEQ_A_CMD, 32'h1);
      set_m[s] = live_m;
      wr(`APSEQ_A_PATH, (s + 1) % 8);
      rdc(`APSEQ_A_STATUS, 32'h2, 32'h2);
    end
    wr(`APSEQ_A_START, 32'h3);
    wr(`APSEQ_A_SET_PICK, 32'h5);
    wr(`APSEQ_A_CMD, 32'h2);
    repeat (5) @(posedge clk);
    load_m(5);
    chk_live(8'h00);
    wr(`APSEQ_A_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    rdc(`APSEQ_A_STATUS, 32'h1, 32'h1);
    wr(`APSEQ_A_CTRL, 32'h2);
    repeat (6) @(posedge clk);
    load_m(3);
    chk({31'h0, run}, 32'h1);
    chk({29'h0, idx}, 32'h3);
    chk({16'h0, live[63:48]}, 32'h0);
    wr(fa(`APSEQ_A_LIVE_BASE, 1), 32'h0000_5a5a);
    live_m[4] = $urandom & 16'hffff;
    wr(fa(`APSEQ_A_LIVE_BASE, 4), live_m[4]);
    chk_live(8'h08);
    for (int k = 1; k <= 4; k++) begin
      trig <= 1'b1;
      repeat (3) @(posedge clk);
      trig <= 1'b0;
      repeat (8 + $urandom % 4) @(posedge clk);
      load_m((3 + k) % 8);
      chk({29'h0, idx}, (3 + k) % 8);
      chk_live(8'h08);
    end
    wr(`APSEQ_A_CTRL, 32'h0);
    repeat (6) @(posedge clk);
    chk({31'h0, run}, 32'h0);
    chk_live(8'h08);
    wr(`APSEQ_A_SET_PICK, 32'h6);
    wr(`APSEQ_A_CMD, 32'h2);
    repeat (5) @(posedge clk);
    load_m(6);
    chk_live(8'h00);
    live_m[0] = set_m[6][0] ^ ($urandom % 32'hffff + 1);
    wr(fa(`APSEQ_A_LIVE_BASE, 0), live_m[0]);
    chk_live(8'h00);
    // stale fixed value recalled in config makes the store illegal
    wr(`APSEQ_A_CTRL, 32'h1);
    wr(`APSEQ_A_SET_PICK, 32'h5);
    wr(`APSEQ_A_CMD, 32'h2);
    repeat (5) @(posedge clk);
    wr(`APSEQ_A_CMD, 32'h1);
    rdc(`APSEQ_A_STATUS, 32'h0, 32'h2);
    wr(`APSEQ_A_SET_PICK, 32'h0);
    rdc(`APSEQ_A_STATUS, 32'h0, 32'h2);
    end_sim();
  end
endmodule // test_apseq_top
